// >>> dv/cbm_exec_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module cbm_exec_chk (
    input wire logic        CLOCK,
    input wire logic        SRST,
    input wire logic        MEM_WE,
    input wire logic        MEM_RE,
    input wire logic        RUN_AUTO,
    input wire logic        STEP_SW,
    input wire logic        INT_REQ,
    input wire logic        INT_SERVICE,
    input wire logic        HALTED,
    input wire logic        HUNG,
    input wire logic [14:0] PROG_PTR,
    input wire logic [23:0] HOLD_INSTR,
    input wire logic [3:0]  COND_OZMC
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);
    // Holding word loads in the first halted cycle, so stability is judged after it
    sequence s_still_halted;
        HALTED ##1 HALTED ##1 HALTED;
    endsequence
    sequence s_step_manual;
        HALTED && !RUN_AUTO && $rose(STEP_SW);
    endsequence
    // Switch sync costs 2-3 cycles, so 6 leaves margin without hiding a dead resume
    stay_halt_a: assert property (RUN_AUTO[*5] ##0 HALTED |=> HALTED)
        else $error("halt lost");
    halt_frozen_a: assert property (s_still_halted |-> $stable(PROG_PTR) && $stable(HOLD_INSTR))
        else $error("halt state moved");
    halt_flags_a: assert property (s_still_halted |-> $stable(COND_OZMC))
        else $error("flags moved in halt");
    halt_quiet_a: assert property (HALTED |-> !MEM_WE)
        else $error("write in halt");
    auto_resume_a: assert property (HALTED && $rose(RUN_AUTO) |-> ##[1:6] !HALTED)
        else $error("auto no resume");
    step_resume_a: assert property (s_step_manual |-> ##[1:6] !HALTED)
        else $error("step no resume");
    int_held_a: assert property (HALTED |-> !INT_SERVICE)
        else $error("service in halt");
    int_after_a: assert property ($fell(HALTED) && INT_REQ |-> ##[0:8] INT_SERVICE)
        else $error("held service lost");
    hang_stay_a: assert property (HUNG |=> HUNG && !MEM_WE)
        else $error("hang left");
    write_after_a: assert property (MEM_WE |-> $past(MEM_RE))
        else $error("write without read");
endmodule : cbm_exec_chk
bind cbm_exec cbm_exec_chk u_chk (.CLOCK, .SRST, .MEM_WE, .MEM_RE, .RUN_AUTO, .STEP_SW, .INT_REQ,
    .INT_SERVICE, .HALTED, .HUNG, .PROG_PTR, .HOLD_INSTR, .COND_OZMC);
`default_nettype wire

// >>> dv/cbm_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module cbm_mem_model (
    input  wire logic        CLOCK,
    input  wire logic [14:0] MEM_ADDR,
    input  wire logic [23:0] MEM_WDATA,
    input  wire logic        MEM_WE,
    input  wire logic        MEM_RE,
    output logic      [23:0] MEM_RDATA
);
    logic [23:0] ram [0:32767];
    logic [23:0] last_ff;
    // The master takes the word at the edge closing its strobe cycle
    // Off that cycle the bus shows the inverse, so a stray sample never matches by luck
    assign MEM_RDATA = MEM_RE ? ram[MEM_ADDR] : ~last_ff;
    always @(posedge CLOCK)
    begin
        if (MEM_WE)
            ram[MEM_ADDR] <= MEM_WDATA;
        if (MEM_RE)
            last_ff <= ram[MEM_ADDR];
    end
endmodule : cbm_mem_model
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "cbm_defs.svh"
module testbench;
    typedef struct {
        logic [23:0] i0, i1, opnd, x_mem, x_a, x_b;
        logic [3:0]  x_cc;
        logic [14:0] x_pc;
    } cbm_row_s;
    localparam logic [23:0] set_a = {`CBM_OP_PAR, 18'h01000};
    localparam logic [23:0] mtst = {`CBM_OP_MTST, 18'h00200};
    localparam logic [23:0] nul = {`CBM_OP_NULL, 18'h0};
    localparam logic [23:0] trap = {`CBM_OP_TRAP, 18'h0};
    localparam logic [23:0] xqt = {`CBM_OP_XQT, 18'h00200};
    localparam logic [23:0] mark = 24'h5a5a5a;
    localparam logic [1:0]  sel_auto = 2'h0;
    localparam logic [1:0]  sel_step = 2'h1;
    localparam logic [1:0]  sel_int = 2'h2;
    logic        clock, srst, start, run_auto, step_sw, int_req, mem_we, mem_re, int_service, halted, hung;
    logic [14:0] mem_addr, prog_ptr;
    logic [23:0] mem_wdata, mem_rdata, acc_a, acc_b, idx_two, idx_three, hold_instr;
    logic [3:0]  cond_ozmc;
    int          bad_count = 0;
    int          n_checks = 0;
    int          svc_cnt = 0;
    cbm_row_s rows [8] = '{
        '{set_a, {`CBM_OP_XOM, 18'h00200}, 24'h0f0f0f, 24'hf0f0f0, 24'hffffff, 24'h0, 4'h2, 15'h104},
        '{mtst, nul, 24'h0, 24'h0, 24'h0, 24'h0, 4'h4, 15'h104},
        '{nul, mtst, 24'h800000, 24'h800000, 24'h0, 24'h0, 4'h2, 15'h104},
        '{set_a, {`CBM_OP_REG, 18'h08000}, 24'h0, 24'h0, 24'hffffff, 24'h0, 4'h2, 15'h104},
        '{{`CBM_OP_MOVER, 18'h18000}, {`CBM_OP_PAR, 18'h0a007}, 24'h0, 24'h0, 24'h010000, 24'h01ffff, 4'h0,
          15'h104},
        '{set_a, {`CBM_OP_PAR, 18'h09017}, 24'h0, 24'h0, 24'h0, 24'h0, 4'h0, 15'h104},
        '{trap, nul, 24'h0, 24'h0, 24'h0, 24'h0, 4'h0, 15'h23},
        '{xqt, nul, trap, trap, 24'h0, 24'h0, 4'h0, 15'h23}
    };
    cbm_exec dut (.CLOCK(clock), .SRST(srst), .CE(1'b1), .START(start), .START_ADDR(15'h100),
        .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_WE(mem_we), .MEM_RE(mem_re), .MEM_RDATA(mem_rdata),
        .RUN_AUTO(run_auto), .STEP_SW(step_sw), .INT_REQ(int_req), .INT_SERVICE(int_service),
        .HALTED(halted), .HUNG(hung), .ACC_A(acc_a), .ACC_B(acc_b), .IDX_TWO(idx_two), .IDX_THREE(idx_three),
        .PROG_PTR(prog_ptr), .HOLD_INSTR(hold_instr), .COND_OZMC(cond_ozmc));
    cbm_mem_model mem (.CLOCK(clock), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_WE(mem_we),
        .MEM_RE(mem_re), .MEM_RDATA(mem_rdata));
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Service is a one-cycle pulse, so it is counted rather than sampled
    always @(posedge clock)
        if (int_service === 1'b1)
            svc_cnt <= svc_cnt + 1;
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic wait_sig(input logic pick_hung, input logic v, input int lim);
        logic cur;
        cur = pick_hung ? hung : halted;
        for (int n = 0; n < lim && cur !== v; n++)
        begin
            @(posedge clock);
            #1;
            cur = pick_hung ? hung : halted;
        end
        // The holding word lands one cycle after the flag, so let that cycle pass
        @(posedge clock);
        #1;
        check("wait level", {23'h0, cur}, {23'h0, v});
    endtask : wait_sig
    task automatic clr_mem;
        for (int a = 0; a < 32768; a++)
            mem.ram[a] = 24'h0;
        mem.ram[1] = 24'h000001;
    endtask : clr_mem
    task automatic boot;
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
    endtask : boot
    task automatic toggle(input logic [1:0] pick, input logic v);
        @(posedge clock);
        case (pick)
            sel_auto: run_auto <= v;
            sel_step: step_sw <= v;
            default:  int_req <= v;
        endcase
        repeat (4) @(posedge clock);
    endtask : toggle
    initial
    begin
        #80000;
        bad_count++;
        print_verdict();
    end
    initial
    begin
        srst = 1'b1;
        start = 1'b0;
        run_auto = 1'b1;
        step_sw = 1'b0;
        int_req = 1'b0;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        foreach (rows[r])
        begin
            clr_mem();
            mem.ram[15'h100] = rows[r].i0;
            mem.ram[15'h101] = rows[r].i1;
            mem.ram[15'h200] = rows[r].opnd;
            mem.ram[rows[r].x_pc - 15'h1] = mark;
            boot();
            wait_sig(1'b0, 1'b1, 200);
            check("halt pointer", prog_ptr, rows[r].x_pc);
            check("holding word", hold_instr, mark);
            check("operand word", mem.ram[15'h200], rows[r].x_mem);
            check("accumulator a", acc_a, rows[r].x_a);
            check("accumulator b", acc_b, rows[r].x_b);
            check("flags", cond_ozmc, rows[r].x_cc);
        end
        clr_mem();
        for (int a = 0; a < 64; a++)
            mem.ram[a] = 24'ha00000 + a;
        mem.ram[15'h100] = {`CBM_OP_PAR, 18'h03000};
        mem.ram[15'h101] = {`CBM_OP_PAR, 18'h04000};
        mem.ram[15'h102] = {`CBM_OP_MOVE, 18'h0003f};
        boot();
        wait_sig(1'b0, 1'b1, 1000);
        check("index three", idx_three, 24'hffffff);
        check("moved first", mem.ram[15'h7fff], 24'ha00000);
        check("moved last", mem.ram[62], 24'ha0003f);
        check("past block", mem.ram[63], 24'ha0003f);
        check("index two", idx_two, 24'h00003f);
        check("accumulator b", acc_b, 24'ha0003f);
        check("move flags", cond_ozmc, 4'h0);
        clr_mem();
        mem.ram[15'h101] = mtst;
        boot();
        wait_sig(1'b0, 1'b1, 200);
        check("stop pointer", prog_ptr, 15'h102);
        check("stop holding", hold_instr, mtst);
        repeat (10) @(posedge clock);
        check("stays halted", halted, 1'b1);
        toggle(sel_auto, 1'b0);
        toggle(sel_auto, 1'b1);
        wait_sig(1'b0, 1'b1, 200);
        check("resumed pointer", prog_ptr, 15'h104);
        check("resumed flags", cond_ozmc, 4'h4);
        toggle(sel_int, 1'b1);
        repeat (6) @(posedge clock);
        check("service held", svc_cnt[23:0], 24'h0);
        toggle(sel_auto, 1'b0);
        toggle(sel_step, 1'b1);
        int_req <= 1'b0;
        // The count is bumped by a non-blocking update at this edge, so look just after it
        #1;
        check("step resume", svc_cnt[23:0], 24'h1);
        toggle(sel_step, 1'b0);
        toggle(sel_auto, 1'b1);
        clr_mem();
        mem.ram[15'h100] = xqt;
        mem.ram[15'h200] = xqt;
        boot();
        wait_sig(1'b1, 1'b1, 200);
        repeat (20) @(posedge clock);
        check("still hung", hung, 1'b1);
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        #1;
        check("reset hang", {hung, halted, prog_ptr}, 17'h0);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire

// >>> rtl/cbm_defs.svh
`ifndef CBM_DEFS_SVH
`define CBM_DEFS_SVH

// Opcode field: instruction bits 23:18 (two octal digits)
`define CBM_OP_XOM       6'h18
`define CBM_OP_HLT       6'h00
`define CBM_OP_MTST      6'h31
`define CBM_OP_REG       6'h09
`define CBM_OP_NULL      6'h06
`define CBM_OP_XQT       6'h38
`define CBM_OP_TRAP      6'h26
`define CBM_OP_PAR       6'h35
`define CBM_OP_MOVE      6'h07
`define CBM_OP_MOVER     6'h3f
// Trap target is location 41 octal
`define CBM_TRAP_ADDR    15'h021
`define CBM_PC_STEP      15'd2
`define CBM_ALL_ONES     24'hffffff
`define CBM_BYTE_MASK_LO 8'hff

`endif

// >>> rtl/cbm_exec.sv
// Function
// - Stop instruction sets halt flip-flop unless run by run-operand
// - Manual-auto toggle or manual step clears halt
// - Interrupt during stop held until resume
// - Halted: pointer is stop address plus two
// - Memory test rewrites word, sets ZM
// - Memory test clears carry
// - Register test rewrites register, ZM, C=0
// - Null instruction changes nothing
// - Run-operand executes word at operand address
// - Run-operand of run-operand hangs until reset
// - Trap loads location 41 octal into holding
// - Parity: copy source, preset destination ones
// - Parity loop: decrement, rotate, XOR, repeat
// - Moves copy 1 to 64 words
// - Moves touch no flags, no address modification
// - Plain move count plus one words via B
// - Plain move advances index two
// - Right move keeps last character in A
// - Right move: B last written, A last read rotated right a byte
`timescale 1ns/1ns
`default_nettype none
`include "cbm_defs.svh"

module cbm_exec (
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic        CE,
    input  wire logic        START,
    input  wire logic [14:0] START_ADDR,
    output logic      [14:0] MEM_ADDR,
    output logic      [23:0] MEM_WDATA,
    output logic             MEM_WE,
    output logic             MEM_RE,
    input  wire logic [23:0] MEM_RDATA,
    input  wire logic        RUN_AUTO,
    input  wire logic        STEP_SW,
    input  wire logic        INT_REQ,
    output logic             INT_SERVICE,
    output logic             HALTED,
    output logic             HUNG,
    output logic      [23:0] ACC_A,
    output logic      [23:0] ACC_B,
    output logic      [23:0] IDX_TWO,
    output logic      [23:0] IDX_THREE,
    output logic      [14:0] PROG_PTR,
    output logic      [23:0] HOLD_INSTR,
    output logic      [3:0]  COND_OZMC
);
    cbm_pkg::cbm_state_e state_ff;
    logic [23:0] regs_ff [0:7];
    logic [23:0] ir_ff;
    logic [23:0] mreg_ff;
    logic [14:0] pc_ff;
    logic [14:0] ea_ff;
    logic [5:0]  cnt_ff;
    logic [3:0]  cc_ff;
    logic        halt_ff;
    logic        int_pend_ff;
    logic        int_svc_ff;
    logic        xq_ff;
    logic [14:0] maddr_ff;
    logic [23:0] mwdata_ff;
    logic        mwe_ff;
    logic        mre_ff;
    logic [1:0]  auto_sync_ff;
    logic [1:0]  step_sync_ff;
    logic        auto_prev_ff;
    logic        step_prev_ff;
    logic        saw_manual_ff;
    logic        resume;
    logic [5:0]  op;
    logic [2:0]  fld_s;
    logic [2:0]  fld_d;
    logic [4:0]  fld_c;
    logic [5:0]  fld_w;

    // Register file index: 0 zero, 1 A, 2 B, 3 index two, 4 index three
    function automatic logic [1:0] zm_of(input logic [23:0] v);
        zm_of = {v == 24'h000000, v[23]};
    endfunction : zm_of

    function automatic logic [23:0] rotl(input logic [23:0] v, input logic [4:0] n);
        logic [47:0] d;
        d = {v, v} << n;
        rotl = d[47:24];
    endfunction : rotl

    // A count of 63 wraps the counter to zero, which still runs 64 words
    function automatic logic [5:0] blk_count(input logic [5:0] c);
        blk_count = c + 6'h01;
    endfunction : blk_count

    assign op    = ir_ff[23:18];
    assign fld_s = ir_ff[17:15];
    assign fld_d = ir_ff[14:12];
    assign fld_c = ir_ff[4:0];
    // Move count field is six bits wide: one to 64 words
    assign fld_w = ir_ff[5:0];

    // Switch pins come from the console, outside the clock domain
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            // Idle at auto, so leaving reset shows no false switch edge
            auto_sync_ff <= 2'h3;
            step_sync_ff <= 2'h0;
        end
        else if (CE)
        begin
            auto_sync_ff <= {auto_sync_ff[0], RUN_AUTO};
            step_sync_ff <= {step_sync_ff[0], STEP_SW};
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            auto_prev_ff  <= 1'b1;
            step_prev_ff  <= 1'b0;
            saw_manual_ff <= 1'b0;
        end
        else if (CE)
        begin
            auto_prev_ff <= auto_sync_ff[1];
            step_prev_ff <= step_sync_ff[1];
            if (!halt_ff)
                saw_manual_ff <= 1'b0;
            else if (!auto_sync_ff[1])
                saw_manual_ff <= 1'b1;
        end
    end

    // Resume on manual-to-auto after a manual visit, or step in manual
    assign resume = halt_ff && ((saw_manual_ff && auto_sync_ff[1] && !auto_prev_ff)
                    || (!auto_sync_ff[1] && step_sync_ff[1] && !step_prev_ff));

    // Interrupts seen during a halt wait until the halt clears
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            int_pend_ff <= 1'b0;
            int_svc_ff  <= 1'b0;
        end
        else if (CE)
        begin
            int_svc_ff <= 1'b0;
            if (halt_ff && !resume)
            begin
                if (INT_REQ)
                    int_pend_ff <= 1'b1;
            end
            else if (int_pend_ff || (INT_REQ && state_ff == cbm_pkg::ST_FETCH))
            begin
                int_pend_ff <= 1'b0;
                int_svc_ff  <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            state_ff  <= cbm_pkg::ST_IDLE;
            for (int i = 0; i < 8; i++)
                regs_ff[i] <= 24'h000000;
            ir_ff     <= 24'h000000;
            mreg_ff   <= 24'h000000;
            pc_ff     <= 15'h0000;
            ea_ff     <= 15'h0000;
            cnt_ff    <= 6'h00;
            cc_ff     <= 4'h0;
            halt_ff   <= 1'b0;
            xq_ff     <= 1'b0;
            maddr_ff  <= 15'h0000;
            mwdata_ff <= 24'h000000;
            mwe_ff    <= 1'b0;
            mre_ff    <= 1'b0;
        end
        else if (CE)
        begin
            mwe_ff <= 1'b0;
            mre_ff <= 1'b0;
            unique case (state_ff)
                cbm_pkg::ST_IDLE:
                begin
                    if (START)
                    begin
                        pc_ff    <= START_ADDR;
                        maddr_ff <= START_ADDR;
                        mre_ff   <= 1'b1;
                        state_ff <= cbm_pkg::ST_FETCH;
                    end
                end
                cbm_pkg::ST_FETCH:
                begin
                    // Read data are valid in the read strobe cycle and taken at its closing edge
                    ir_ff    <= MEM_RDATA;
                    xq_ff    <= 1'b0;
                    pc_ff    <= pc_ff + 15'd1;
                    state_ff <= cbm_pkg::ST_DEC;
                end
                cbm_pkg::ST_XFET:
                begin
                    if (MEM_RDATA[23:18] == `CBM_OP_XQT)
                        state_ff <= cbm_pkg::ST_HANG;
                    else
                    begin
                        ir_ff    <= MEM_RDATA;
                        xq_ff    <= 1'b1;
                        state_ff <= cbm_pkg::ST_DEC;
                    end
                end
                cbm_pkg::ST_DEC:
                begin
                    ea_ff <= ir_ff[14:0];
                    if (op == `CBM_OP_XOM || op == `CBM_OP_MTST || op == `CBM_OP_XQT)
                    begin
                        maddr_ff <= ir_ff[14:0];
                        mre_ff   <= 1'b1;
                        state_ff <= (op == `CBM_OP_XQT) ? cbm_pkg::ST_XFET : cbm_pkg::ST_OPRD;
                    end
                    else if (op == `CBM_OP_MOVE || op == `CBM_OP_MOVER)
                    begin
                        // Count field only; addresses come from index two and index three, not the address field
                        cnt_ff   <= blk_count(fld_w);
                        state_ff <= cbm_pkg::ST_MVRD;
                    end
                    else if (op == `CBM_OP_PAR)
                    begin
                        mreg_ff      <= regs_ff[fld_s];
                        if (fld_d != 3'd0)
                            regs_ff[fld_d] <= `CBM_ALL_ONES;
                        // Count is taken as given; a larger one only rotates further
                        cnt_ff       <= {1'b0, fld_c};
                        state_ff     <= cbm_pkg::ST_PAR;
                    end
                    else
                        state_ff <= cbm_pkg::ST_EXEC;
                end
                cbm_pkg::ST_OPRD:
                begin
                    maddr_ff <= ea_ff;
                    mwe_ff   <= 1'b1;
                    if (op == `CBM_OP_XOM)
                    begin
                        mwdata_ff  <= regs_ff[1] ^ MEM_RDATA;
                        cc_ff[2:1] <= zm_of(regs_ff[1] ^ MEM_RDATA);
                    end
                    else
                    begin
                        mwdata_ff  <= MEM_RDATA + regs_ff[0];
                        cc_ff[2:1] <= zm_of(MEM_RDATA);
                    end
                    cc_ff[0] <= 1'b0;
                    state_ff <= cbm_pkg::ST_EXEC;
                end
                cbm_pkg::ST_PAR:
                begin
                    if (cnt_ff == 6'h00)
                        state_ff <= cbm_pkg::ST_EXEC;
                    else
                    begin
                        cnt_ff  <= cnt_ff - 6'd1;
                        mreg_ff <= rotl(mreg_ff, 5'd1);
                        if (fld_d != 3'd0)
                            regs_ff[fld_d] <= regs_ff[fld_d] ^ rotl(mreg_ff, 5'd1);
                    end
                end
                cbm_pkg::ST_MVRD:
                begin
                    regs_ff[3] <= regs_ff[3] + 24'd1;
                    maddr_ff   <= regs_ff[3][14:0] + 15'd1;
                    mre_ff     <= 1'b1;
                    state_ff   <= cbm_pkg::ST_MVWR;
                end
                cbm_pkg::ST_MVWR:
                begin
                    maddr_ff <= regs_ff[3][14:0] + regs_ff[4][14:0];
                    mwe_ff   <= 1'b1;
                    if (op == `CBM_OP_MOVER)
                    begin
                        // Left byte of A carries in; word leaves shifted right a byte
                        mwdata_ff  <= {regs_ff[1][23:16], MEM_RDATA[23:8]};
                        regs_ff[2] <= {regs_ff[1][23:16], MEM_RDATA[23:8]};
                        regs_ff[1] <= {MEM_RDATA[7:0], MEM_RDATA[23:8]};
                    end
                    else
                    begin
                        mwdata_ff  <= MEM_RDATA;
                        regs_ff[2] <= MEM_RDATA;
                    end
                    cnt_ff   <= cnt_ff - 6'd1;
                    // Index two steps per word, so it ends advanced by count plus one
                    state_ff <= (cnt_ff == 6'd1) ? cbm_pkg::ST_EXEC : cbm_pkg::ST_MVRD;
                end
                cbm_pkg::ST_EXEC:
                begin
                    if (op == `CBM_OP_HLT && !xq_ff)
                    begin
                        halt_ff  <= 1'b1;
                        pc_ff    <= pc_ff + 15'd1;
                        maddr_ff <= pc_ff;
                        mre_ff   <= 1'b1;
                        state_ff <= cbm_pkg::ST_HALT;
                    end
                    else
                    begin
                        if (op == `CBM_OP_REG && ir_ff[14:12] == 3'd0 && fld_s != 3'd0)
                        begin
                            regs_ff[fld_s] <= regs_ff[fld_s] + regs_ff[0];
                            cc_ff[2:1]     <= zm_of(regs_ff[fld_s]);
                            cc_ff[0]       <= 1'b0;
                        end
                        // Null instruction falls through here untouched
                        if (op == `CBM_OP_TRAP)
                        begin
                            pc_ff    <= `CBM_TRAP_ADDR;
                            maddr_ff <= `CBM_TRAP_ADDR;
                        end
                        else
                            maddr_ff <= pc_ff;
                        mre_ff   <= 1'b1;
                        state_ff <= cbm_pkg::ST_FETCH;
                    end
                end
                cbm_pkg::ST_HALT:
                begin
                    if (!mre_ff && maddr_ff == pc_ff - 15'd1)
                        ir_ff <= ir_ff;
                    if (mre_ff)
                        ir_ff <= MEM_RDATA;
                    if (resume)
                    begin
                        halt_ff  <= 1'b0;
                        // Holding register already has the next instruction
                        state_ff <= cbm_pkg::ST_DEC;
                    end
                end
                cbm_pkg::ST_HANG:
                begin
                    state_ff <= cbm_pkg::ST_HANG;
                end
                default:
                    state_ff <= cbm_pkg::ST_IDLE;
            endcase
        end
    end

    assign MEM_ADDR    = maddr_ff;
    assign MEM_WDATA   = mwdata_ff;
    assign MEM_WE      = mwe_ff;
    assign MEM_RE      = mre_ff;
    assign INT_SERVICE = int_svc_ff;
    assign HALTED      = halt_ff;
    assign HUNG        = (state_ff == cbm_pkg::ST_HANG);
    assign ACC_A       = regs_ff[1];
    assign ACC_B       = regs_ff[2];
    assign IDX_TWO     = regs_ff[3];
    assign IDX_THREE   = regs_ff[4];
    assign PROG_PTR    = pc_ff;
    assign HOLD_INSTR  = ir_ff;
    assign COND_OZMC   = cc_ff;
endmodule : cbm_exec
`default_nettype wire

// >>> rtl/cbm_pkg.sv
package cbm_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_FETCH = 4'h1,
        ST_DEC   = 4'h2,
        ST_OPRD  = 4'h3,
        ST_EXEC  = 4'h4,
        ST_PAR   = 4'h5,
        ST_MVRD  = 4'h6,
        ST_MVWR  = 4'h7,
        ST_HALT  = 4'h8,
        ST_HANG  = 4'h9,
        ST_XFET  = 4'ha
    } cbm_state_e;
endpackage : cbm_pkg
